// file: design/ccr_ctl.sv
// Capture channel control: reset trigger, capture block, raw field id.
// Assumes video pins are asynchronous and the DMA side shares clk.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module ccr_ctl #(
    parameter int DW    = ccr_pkg::DATA_W,
    parameter int DEPTH = ccr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // Register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    // Video pins
    input  wire logic          vid_vsync,
    input  wire logic          vid_field,
    input  wire logic          vid_strobe,
    input  wire logic [DW-1:0] vid_data,
    // DMA side
    output logic [DW-1:0]      dma_data,
    output logic               dma_valid,
    input  wire logic          dma_ready,
    input  wire logic          dma_busy,
    // Event pulses
    output logic               field_event,
    output logic               vsync_event
);
    typedef struct packed {
        logic                       en;
        logic                       blk;
        logic                       raw_field_id_enable;
        logic                       rst_trig;
        logic                       f1;
        logic                       f2;
        logic                       frm;
        logic                       ovr;
        ccr_pkg::ccr_cap_state_type cstate;
        ccr_pkg::ccr_rst_state_type rstate;
        logic                       vs_s1;
        logic                       vs_s2;
        logic                       vs_d;
        logic                       fld_s1;
        logic                       fld_s2;
        logic                       stb_s1;
        logic                       stb_s2;
        logic                       stb_d;
        logic [DW-1:0]              dat_s1;
        logic [DW-1:0]              dat_s2;
        logic                       cur_field;
        logic                       fev;
        logic                       vev;
        logic [31:0]                rdata;
    } ccr_ctl_state_type;

    ccr_ctl_state_type st;
    ccr_ctl_state_type next_st;

    logic          wr_ctl;
    logic          wr_sts;
    logic          vs_rise;
    logic          frame_start;
    logic          running;
    logic          events_on;
    logic          flush;
    logic          push;
    logic          in_ready;
    logic          out_valid;
    logic          set_f1;
    logic          set_f2;
    logic          set_frm;
    logic          clr_f1;
    logic          clr_f2;
    logic          clr_frm;
    logic [31:0]   ctl_word;
    logic [31:0]   sts_word;

    // Flush is held while blocked, so a blocked channel never holds data.
    assign flush = st.blk || (st.rstate == ccr_pkg::RST_FLUSH);

    // DMA only runs once the channel has synced and no reset is pending.
    assign events_on = (st.cstate == ccr_pkg::CAP_RUN) && st.en
                       && !st.blk
                       && (st.rstate == ccr_pkg::RST_IDLE);

    assign dma_valid   = out_valid && events_on;
    assign reg_rdata   = st.rdata;
    assign field_event = st.fev;
    assign vsync_event = st.vev;

    ccr_fifo #(
        .W (DW),
        .D (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (in_ready),
        .in_data   (st.dat_s2),
        .out_valid (out_valid),
        .out_ready (dma_ready && events_on),
        .out_data  (dma_data)
    );

    always_comb begin
        next_st = st;
        wr_ctl  = reg_wr && (reg_addr == ccr_pkg::CTL_OFF);
        wr_sts  = reg_wr && (reg_addr == ccr_pkg::STS_OFF);

        // Two-flop synchronisers for every video pin.
        next_st.vs_s1  = vid_vsync;
        next_st.vs_s2  = st.vs_s1;
        next_st.vs_d   = st.vs_s2;
        next_st.fld_s1 = vid_field;
        next_st.fld_s2 = st.fld_s1;
        next_st.stb_s1 = vid_strobe;
        next_st.stb_s2 = st.stb_s1;
        next_st.stb_d  = st.stb_s2;
        next_st.dat_s1 = vid_data;
        next_st.dat_s2 = st.dat_s1;

        vs_rise = st.vs_s2 && !st.vs_d;
        // Without field identification every vertical sync opens a frame.
        frame_start = vs_rise && (!st.raw_field_id_enable || !st.fld_s2);
        running = (st.cstate == ccr_pkg::CAP_RUN) && st.en
                  && !st.blk;

        // Pixels arriving while the FIFO is full are dropped and noted.
        push = running && st.stb_s2 && !st.stb_d;
        if (push && !in_ready) begin
            next_st.ovr = 1'b1;
        end

        if (vs_rise) begin
            next_st.cur_field = st.raw_field_id_enable ? st.fld_s2 : 1'b0;
        end

        // Flags and event pulses stay quiet while capture is blocked.
        set_f1  = vs_rise && running && !st.cur_field;
        set_f2  = vs_rise && running && st.cur_field;
        set_frm = vs_rise && running
                  && (st.cur_field || !st.raw_field_id_enable);
        next_st.fev = set_f1 || set_f2;
        next_st.vev = vs_rise && running;

        // Software clears the flags by writing ones; a new event wins.
        clr_f1  = wr_sts && reg_wdata[ccr_pkg::F1_BIT];
        clr_f2  = wr_sts && reg_wdata[ccr_pkg::F2_BIT];
        clr_frm = wr_sts && reg_wdata[ccr_pkg::FRM_BIT];
        next_st.f1  = (st.f1 && !clr_f1) || set_f1;
        next_st.f2  = (st.f2 && !clr_f2) || set_f2;
        next_st.frm = (st.frm && !clr_frm) || set_frm;
        if (wr_sts && reg_wdata[ccr_pkg::OVR_BIT]) begin
            next_st.ovr = push && !in_ready;
        end

        case (st.cstate)
            ccr_pkg::CAP_BLOCK: begin
                if (!st.blk) begin
                    next_st.cstate = ccr_pkg::CAP_SYNC;
                end
            end
            ccr_pkg::CAP_SYNC: begin
                // The rest of the current field and frame is skipped.
                if (st.blk) begin
                    next_st.cstate = ccr_pkg::CAP_BLOCK;
                end else if (frame_start) begin
                    next_st.cstate = ccr_pkg::CAP_RUN;
                end
            end
            ccr_pkg::CAP_RUN: begin
                if (st.blk) begin
                    next_st.cstate = ccr_pkg::CAP_BLOCK;
                end
            end
            default: begin
                next_st.cstate = ccr_pkg::CAP_BLOCK;
            end
        endcase

        case (st.rstate)
            ccr_pkg::RST_IDLE: begin
                if (wr_ctl && reg_wdata[ccr_pkg::RST_BIT]) begin
                    // Other bits of the same write are dropped by the reset.
                    next_st.rst_trig = 1'b1;
                    next_st.rstate   = ccr_pkg::RST_DRAIN;
                end else if (wr_ctl) begin
                    // A zero in the reset bit does nothing.
                    next_st.blk = reg_wdata[ccr_pkg::BLK_BIT];
                    next_st.en  = reg_wdata[ccr_pkg::EN_BIT];
                    if (!st.en) begin
                        next_st.raw_field_id_enable = reg_wdata[ccr_pkg::RAW_FIELD_ID_ENABLE_BIT];
                    end
                end
            end
            ccr_pkg::RST_DRAIN: begin
                // Wait for transfers already granted before flushing.
                if (!dma_busy) begin
                    next_st.rstate = ccr_pkg::RST_FLUSH;
                end
            end
            ccr_pkg::RST_FLUSH: begin
                next_st.en       = ccr_pkg::EN_INIT;
                next_st.blk      = ccr_pkg::BLK_INIT;
                next_st.raw_field_id_enable     = ccr_pkg::RAW_FIELD_ID_ENABLE_INIT;
                next_st.f1       = 1'b0;
                next_st.f2       = 1'b0;
                next_st.frm      = 1'b0;
                next_st.ovr      = 1'b0;
                next_st.cstate   = ccr_pkg::CAP_BLOCK;
                next_st.rst_trig = 1'b0;
                next_st.rstate   = ccr_pkg::RST_IDLE;
            end
            default: begin
                next_st.rstate = ccr_pkg::RST_IDLE;
            end
        endcase

        // Reserved bits are left at zero in both words.
        ctl_word = '0;
        ctl_word[ccr_pkg::RST_BIT]  = st.rst_trig;
        ctl_word[ccr_pkg::BLK_BIT]  = st.blk;
        ctl_word[ccr_pkg::RAW_FIELD_ID_ENABLE_BIT] = st.raw_field_id_enable;
        ctl_word[ccr_pkg::EN_BIT]   = st.en;
        sts_word = '0;
        sts_word[ccr_pkg::F1_BIT]  = st.f1;
        sts_word[ccr_pkg::F2_BIT]  = st.f2;
        sts_word[ccr_pkg::FRM_BIT] = st.frm;
        sts_word[ccr_pkg::RUN_BIT] = events_on;
        sts_word[ccr_pkg::OVR_BIT] = st.ovr;

        next_st.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ccr_pkg::CTL_OFF: next_st.rdata = ctl_word;
                ccr_pkg::STS_OFF: next_st.rdata = sts_word;
                default:          next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st     <= '0;
            st.blk <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule

// file: design/ccr_pkg.sv
// Constants and types for the capture channel reset and block control.
// Assumes a single 20 MHz clock and a plain register port.
package ccr_pkg;

    localparam logic [7:0] CTL_OFF  = 8'h00;
    localparam logic [7:0] STS_OFF  = 8'h04;

    localparam int RST_BIT  = 31;
    localparam int BLK_BIT  = 30;
    localparam int RAW_FIELD_ID_ENABLE_BIT = 21;
    localparam int EN_BIT   = 15;

    localparam int F1_BIT   = 28;
    localparam int F2_BIT   = 29;
    localparam int FRM_BIT  = 30;
    localparam int RUN_BIT  = 1;
    localparam int OVR_BIT  = 0;

    localparam logic BLK_INIT  = 1'b1;
    localparam logic EN_INIT   = 1'b0;
    localparam logic RAW_FIELD_ID_ENABLE_INIT = 1'b0;

    localparam int DATA_W     = 10;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        CAP_BLOCK = 2'b00,
        CAP_SYNC  = 2'b01,
        CAP_RUN   = 2'b10
    } ccr_cap_state_type;

    typedef enum logic [1:0] {
        RST_IDLE  = 2'b00,
        RST_DRAIN = 2'b01,
        RST_FLUSH = 2'b10
    } ccr_rst_state_type;

endpackage

// file: design/ccr_fifo.sv
// Capture FIFO with valid and ready on both sides and a flush input.
// Assumes flush and traffic come from the same clock domain.
`timescale 1ns/1ps
module ccr_fifo #(
    parameter int W = ccr_pkg::DATA_W,
    parameter int D = ccr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Flush, drops every stored word
    input  wire logic         flush,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } ccr_fifo_state_type;

    ccr_fifo_state_type st;
    ccr_fifo_state_type next_st;
    logic               push;
    logic               pop;

    assign in_ready  = (st.cnt != FULL);
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rp];

    always_comb begin
        next_st = st;
        push    = in_valid && in_ready;
        pop     = out_valid && out_ready;
        if (flush) begin
            next_st.wp  = '0;
            next_st.rp  = '0;
            next_st.cnt = '0;
        end else begin
            if (push) begin
                next_st.mem[st.wp] = in_data;
                next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
            end
            if (pop) begin
                next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
            end
            if (push && !pop) begin
                next_st.cnt = st.cnt + 1'b1;
            end else if (pop && !push) begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// file: testbench/ccr_ctl_properties.sv
// Port checks for the capture channel control block.
// Assumes software never writes control during a channel reset.
`timescale 1ns/1ps
module ccr_ctl_properties #(
    parameter int DW = 10
) (
    // Clock and reset
    input wire logic          clk,
    input wire logic          reset_n,
    // Register port
    input wire logic [7:0]    reg_addr,
    input wire logic [31:0]   reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [31:0]   reg_rdata,
    // DMA side and events
    input wire logic [DW-1:0] dma_data,
    input wire logic          dma_valid,
    input wire logic          dma_ready,
    input wire logic          field_event,
    input wire logic          vsync_event
);
    logic blk_q;
    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = reg_wr && reg_addr == ccr_pkg::CTL_OFF;
    assign ctl_rd = reg_rd && reg_addr == ccr_pkg::CTL_OFF;
    // A channel reset also leaves the block bit set.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blk_q <= 1'b1;
        end else if (ctl_wr) begin
            blk_q <= reg_wdata[31] | reg_wdata[30];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    rsv_zero_a: assert property (
        $past(ctl_rd) |-> (reg_rdata & 32'h3FDF_7FFF) == 32'h0000_0000)
        else $error("control reads nonzero in unused bits");
    unmapped_zero_a: assert property (
        $past(reg_rd && reg_addr != ccr_pkg::CTL_OFF
            && reg_addr != ccr_pkg::STS_OFF) |-> reg_rdata == 32'h0000_0000)
        else $error("unmapped read is nonzero");
    blk_no_dma_a: assert property (
        blk_q |-> !dma_valid)
        else $error("words offered while blocked");
    blk_no_event_a: assert property (
        blk_q |-> !field_event && !vsync_event)
        else $error("event while blocked");
    clear_wait_a: assert property (
        $fell(blk_q) |-> (!dma_valid && !field_event) [*8])
        else $error("capture resumed at once after clear");
    rst_stop_a: assert property (
        ctl_wr && reg_wdata[31] |=> !dma_valid [*2])
        else $error("words offered during channel reset");
    blk_back_a: assert property (
        $past(ctl_rd) && !reg_rdata[31] |-> reg_rdata[30] == $past(blk_q))
        else $error("block bit reads wrong");
    pulse_a: assert property (
        field_event |=> !field_event)
        else $error("field event longer than one cycle");
    dma_hold_a: assert property (
        dma_valid && !dma_ready && !ctl_wr |=> dma_valid && $stable(dma_data))
        else $error("head word lost while stalled");
    cover property (dma_valid && dma_ready);
    cover property (field_event);
    cover property ($fell(blk_q));
endmodule
bind ccr_ctl ccr_ctl_properties #(.DW(DW)) u_ccr_ctl_properties (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dma_data(dma_data), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .field_event(field_event),
    .vsync_event(vsync_event));

// file: testbench/ccr_vid_model.sv
// Video source and DMA sink facing the capture control block.
// Assumes the bench sets dma_ready and dma_busy and calls the tasks.
`timescale 1ns/1ps
module ccr_vid_model #(
    parameter int DW = 10
) (
    // Clock
    input  wire logic          clk,
    // Video pins
    output logic               vid_vsync,
    output logic               vid_field,
    output logic               vid_strobe,
    output logic [DW-1:0]      vid_data,
    // DMA side
    input  wire logic [DW-1:0] dma_data,
    input  wire logic          dma_valid,
    output logic               dma_ready,
    output logic               dma_busy
);
    logic [DW-1:0] got[$];
    initial begin
        vid_vsync  = 1'b0;
        vid_field  = 1'b0;
        vid_strobe = 1'b0;
        vid_data   = '0;
        dma_ready  = 1'b1;
        dma_busy   = 1'b0;
    end
    always @(posedge clk) begin
        if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
            got.push_back(dma_data);
        end
    end
    // Pulses are held several cycles so the pin synchronisers see them.
    task automatic frame(input logic fld);
        @(posedge clk) vid_field <= fld;
        repeat (2) @(posedge clk);
        vid_vsync <= 1'b1;
        repeat (5) @(posedge clk);
        vid_vsync <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    // Data is inverted after the strobe so a stale word never looks valid.
    task automatic pixel(input logic [DW-1:0] d);
        @(posedge clk) vid_data <= d;
        repeat (3) @(posedge clk);
        vid_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        vid_strobe <= 1'b0;
        vid_data   <= ~d;
    endtask
endmodule

// file: testbench/ccr_ctl_test.sv
// Self-checking bench for the capture channel control block.
// Assumes the video and DMA partner in ccr_vid_model.
`timescale 1ns/1ps
module ccr_ctl_test;
    logic        clk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        vid_vsync;
    logic        vid_field;
    logic        vid_strobe;
    logic [9:0]  vid_data;
    logic [9:0]  dma_data;
    logic        dma_valid;
    logic        dma_ready;
    logic        dma_busy;
    logic        field_event;
    logic        vsync_event;
    int          err_count;
    int          tests_run;
    int          ev_cnt;
    int          vs_cnt;
    int          ev_base;
    int          vs_base;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    ccr_ctl u_ccr_ctl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vid_vsync(vid_vsync), .vid_field(vid_field),
        .vid_strobe(vid_strobe), .vid_data(vid_data), .dma_data(dma_data),
        .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_busy(dma_busy),
        .field_event(field_event), .vsync_event(vsync_event));
    ccr_vid_model u_ccr_vid_model (.clk(clk), .vid_vsync(vid_vsync),
        .vid_field(vid_field), .vid_strobe(vid_strobe),
        .vid_data(vid_data), .dma_data(dma_data), .dma_valid(dma_valid),
        .dma_ready(dma_ready), .dma_busy(dma_busy));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (field_event === 1'b1) begin
            ev_cnt <= ev_cnt + 1;
        end
        if (vsync_event === 1'b1) begin
            vs_cnt <= vs_cnt + 1;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string n);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        cmp(n, e, reg_rdata & m);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        chk(ccr_pkg::CTL_OFF, ALL, 32'h4000_0000, "ctl init");
        chk(ccr_pkg::STS_OFF, ALL, 32'h0000_0000, "sts init");
        chk(8'h08, ALL, 32'h0000_0000, "unmapped");
        wr(ccr_pkg::CTL_OFF, 32'h7FC0_0000);
        chk(ccr_pkg::CTL_OFF, ALL, 32'h4000_0000, "reserved");
        wr(ccr_pkg::CTL_OFF, 32'h0020_0000);
        wr(ccr_pkg::CTL_OFF, 32'h0020_8000);
        chk(ccr_pkg::CTL_OFF, ALL, 32'h0020_8000, "ctl run");
        $display("test registers done");
        u_ccr_vid_model.frame(1'b1);
        u_ccr_vid_model.pixel(10'h155);
        cmp("sync words", 0, u_ccr_vid_model.got.size());
        u_ccr_vid_model.frame(1'b0);
        wr(ccr_pkg::STS_OFF, 32'h7000_0001);
        u_ccr_vid_model.pixel(10'h2AA);
        u_ccr_vid_model.pixel(10'h0F0);
        repeat (4) @(posedge clk);
        cmp("run words", 2, u_ccr_vid_model.got.size());
        cmp("word 0", 32'h2AA, 32'(u_ccr_vid_model.got[0]));
        cmp("word 1", 32'h0F0, 32'(u_ccr_vid_model.got[1]));
        u_ccr_vid_model.frame(1'b1);
        chk(ccr_pkg::STS_OFF, ALL, 32'h1000_0002, "field one");
        u_ccr_vid_model.frame(1'b0);
        chk(ccr_pkg::STS_OFF, ALL, 32'h7000_0002, "field two");
        cmp("events", 2, ev_cnt);
        cmp("vsync events", 2, vs_cnt);
        $display("test capture done");
        u_ccr_vid_model.got.delete();
        u_ccr_vid_model.dma_ready <= 1'b0;
        for (int i = 0; i < 33; i++) begin
            u_ccr_vid_model.pixel(i[9:0]);
        end
        chk(ccr_pkg::STS_OFF, 32'h0000_0001, 32'h0000_0001, "full");
        u_ccr_vid_model.dma_ready <= 1'b1;
        repeat (40) @(posedge clk);
        cmp("drained", 32, u_ccr_vid_model.got.size());
        for (int i = 0; i < 32; i++) begin
            cmp("fifo word", i, 32'(u_ccr_vid_model.got[i]));
        end
        $display("test fifo done");
        u_ccr_vid_model.dma_ready <= 1'b0;
        u_ccr_vid_model.pixel(10'h003);
        u_ccr_vid_model.pixel(10'h004);
        wr(ccr_pkg::CTL_OFF, 32'h4020_8000);
        u_ccr_vid_model.got.delete();
        u_ccr_vid_model.dma_ready <= 1'b1;
        wr(ccr_pkg::STS_OFF, 32'h7000_0001);
        ev_base = ev_cnt;
        vs_base = vs_cnt;
        u_ccr_vid_model.frame(1'b1);
        u_ccr_vid_model.frame(1'b0);
        u_ccr_vid_model.pixel(10'h005);
        chk(ccr_pkg::STS_OFF, ALL, 32'h0000_0000, "blk flags");
        cmp("blk events", 0, ev_cnt - ev_base);
        cmp("blk vsync", 0, vs_cnt - vs_base);
        cmp("blk words", 0, u_ccr_vid_model.got.size());
        chk(ccr_pkg::CTL_OFF, ALL, 32'h4020_8000, "blk keep");
        $display("test block done");
        wr(ccr_pkg::CTL_OFF, 32'h0020_8000);
        u_ccr_vid_model.frame(1'b0);
        u_ccr_vid_model.dma_ready <= 1'b0;
        u_ccr_vid_model.dma_busy  <= 1'b1;
        u_ccr_vid_model.pixel(10'h006);
        wr(ccr_pkg::CTL_OFF, 32'h8000_0000);
        chk(ccr_pkg::CTL_OFF, 32'h8000_0000, 32'h8000_0000, "busy");
        u_ccr_vid_model.dma_ready <= 1'b1;
        repeat (10) @(posedge clk);
        cmp("rst words", 0, u_ccr_vid_model.got.size());
        u_ccr_vid_model.dma_busy <= 1'b0;
        repeat (5) @(posedge clk);
        chk(ccr_pkg::CTL_OFF, ALL, 32'h4000_0000, "rst ctl");
        chk(ccr_pkg::STS_OFF, ALL, 32'h0000_0000, "rst sts");
        $display("test channel reset done");
        wr(ccr_pkg::CTL_OFF, 32'h0000_8000);
        wr(ccr_pkg::CTL_OFF, 32'h0020_8000);
        chk(ccr_pkg::CTL_OFF, ALL, 32'h0000_8000, "raw_field_id_enable locked");
        u_ccr_vid_model.frame(1'b1);
        u_ccr_vid_model.frame(1'b1);
        chk(ccr_pkg::STS_OFF, ALL, 32'h5000_0002, "raw off");
        $display("test raw field id off done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk(ccr_pkg::CTL_OFF, ALL, 32'h4000_0000, "again ctl");
        chk(ccr_pkg::STS_OFF, ALL, 32'h0000_0000, "again sts");
        $display("test mid reset done");
        wrap_up();
    end
endmodule
